// ### icg_pkg.sv
// Package of constants for the interrupt/DMA gating and floppy configuration block.
package icg_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ACTIVATE    = 8'h30;
  localparam logic [7:0] IDX_IRQ_SELECT  = 8'h70;
  localparam logic [7:0] IDX_DMA_SELECT  = 8'h74;
  localparam logic [7:0] IDX_MODE        = 8'hF0;
  localparam logic [7:0] IDX_OPTION      = 8'hF1;
  localparam logic [7:0] IDX_DRIVE_TYPES = 8'hF2;
  localparam logic [7:0] IDX_RSVD_ZERO   = 8'hF3;
  localparam logic [7:0] IDX_DRIVE0      = 8'hF4;
  localparam logic [7:0] IDX_DRIVE1      = 8'hF5;

  // ----------------------------------------------------------------
  // Logical device numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] LDN_FLOPPY   = 8'h00;
  localparam logic [7:0] LDN_PARALLEL = 8'h03;
  localparam logic [7:0] LDN_SERIAL1  = 8'h04;
  localparam logic [7:0] LDN_SERIAL2  = 8'h05;
  localparam int         NUM_DEV      = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_FLOPPY  = 8'h06;
  localparam logic [7:0] RST_IRQ_OTHER   = 8'h00;
  localparam logic [7:0] RST_DMA_FLOPPY  = 8'h02;
  localparam logic [7:0] RST_DMA_OTHER   = 8'h04;
  localparam logic [7:0] RST_MODE        = 8'h0E;
  localparam logic [7:0] RST_OPTION      = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPES = 8'hFF;
  localparam logic [7:0] RST_DRIVE       = 8'h00;
  localparam logic [7:0] DRIVE_WR_MASK   = 8'h5B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_ENHANCED  = 0;
  localparam int MODE_NONBURST  = 1;
  localparam int MODE_IF_LSB    = 2;
  localparam int MODE_SWAP      = 4;
  localparam int MODE_PUSHPULL  = 6;
  localparam int MODE_TRISTATE  = 7;
  localparam int DOR_DMA_GATE   = 3;
  localparam int PCTL_IRQ_EN    = 4;
  localparam int ECR_SVC_MASK   = 2;
  localparam int ECR_DMA_EN     = 3;
  localparam int ECR_MODE_LSB   = 5;
  localparam int MODEM_AUX2     = 3;
  localparam int DRV_TYPE_LSB   = 0;
  localparam int DRV_RATE_LSB   = 3;
  localparam int DRV_PRECOMP    = 6;

  localparam logic [3:0] IRQ_NONE  = 4'h0;
  localparam logic [2:0] DMA_FIRST = 3'h1;
  localparam logic [2:0] DMA_LAST  = 3'h3;

  typedef enum logic [1:0] {IF_BASIC, IF_ALT, IF_RSVD, IF_AT} icg_ifmode_e;
  typedef enum logic [2:0] {
    ECR_PRINTER, ECR_SPP, ECR_FIFO, ECR_ECP, ECR_EPP, ECR_RES, ECR_TEST, ECR_CONFIG
  } icg_ecr_e;

endpackage

// ### icg_line_gate.sv
// Route one device's interrupt and DMA requests onto the selected shared lines.
`timescale 1ns/1ns
module icg_line_gate #(
  parameter int NUM_IRQ = 16,
  parameter int NUM_DMA = 4
) (
  input  wire logic [3:0]         irqSel,
  input  wire logic [2:0]         dmaSel,
  input  wire logic               irqReq,
  input  wire logic               dmaReq,
  output logic      [NUM_IRQ-1:0] irqLines,
  output logic      [NUM_DMA-1:0] dmaLines,
  output logic                    dmaValid
);

  initial begin
    if (NUM_IRQ != 16 || NUM_DMA != 4) $error("icg_line_gate: unsupported line count");
  end

  always_comb begin
    irqLines = '0;
    dmaLines = '0;
    dmaValid = (dmaSel >= icg_pkg::DMA_FIRST) && (dmaSel <= icg_pkg::DMA_LAST);
    if (irqSel != icg_pkg::IRQ_NONE) begin
      irqLines[irqSel] = irqReq;
    end
    if (dmaValid) begin
      dmaLines[dmaSel[1:0]] = dmaReq;
    end
  end

endmodule

// ### icg_config_regs.sv
// Configuration registers with interrupt/DMA gating and floppy vendor settings.
`timescale 1ns/1ns
module icg_config_regs #(
  parameter int NUM_IRQ = 16,
  parameter int NUM_DMA = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               bus_reset_n,
  input  wire logic               softReset,
  input  wire logic [7:0]         ldnSel,
  input  wire logic [7:0]         cfgIndex,
  input  wire logic [7:0]         cfgWdata,
  input  wire logic               cfgWrite,
  input  wire logic               cfgRead,
  output logic      [7:0]         cfgRdata,
  input  wire logic [3:0]         devAddrValid,
  input  wire logic [7:0]         floppyDor,
  input  wire logic               floppyPowerDown,
  input  wire logic               floppyIrq,
  input  wire logic               floppyDrq,
  input  wire logic [7:0]         parControl,
  input  wire logic [7:0]         parEcr,
  input  wire logic               parEppMode,
  input  wire logic               parIrq,
  input  wire logic               parDrq,
  input  wire logic [7:0]         uart1IrqEnable,
  input  wire logic [7:0]         uart1ModemControl,
  input  wire logic               uart1Irq,
  input  wire logic [7:0]         uart2IrqEnable,
  input  wire logic [7:0]         uart2ModemControl,
  input  wire logic               uart2Irq,
  input  wire logic               uart2DmaEnable,
  input  wire logic               uart2Drq,
  input  wire logic [1:0]         driveSelectRaw_n,
  input  wire logic [1:0]         motorOnRaw_n,
  output logic      [NUM_IRQ-1:0] irqOut,
  output logic      [NUM_DMA-1:0] dmaReqOut,
  output logic      [1:0]         drive_select_n,
  output logic      [1:0]         motor_on_n,
  output logic      [3:0]         floppyPinOe,
  output logic                    floppyPushPull,
  output logic                    floppyEnhanced,
  output logic                    floppyNonBurst,
  output logic      [1:0]         floppyIfMode,
  output logic      [7:0]         floppyOption,
  output logic      [7:0]         floppyDriveTypes,
  output logic      [1:0]         driveTypeSel0,
  output logic      [1:0]         rateTableSel0,
  output logic                    precompDisable0,
  output logic      [1:0]         driveTypeSel1,
  output logic      [1:0]         rateTableSel1,
  output logic                    precompDisable1
);

  initial begin
    if (NUM_IRQ != 16 || NUM_DMA != 4) $error("icg_config_regs: unsupported line count");
  end

  // ----------------------------------------------------------------
  // Per-device standard registers
  // ----------------------------------------------------------------
  logic [3:0] activate;
  logic [3:0] irqSel   [icg_pkg::NUM_DEV];
  logic [2:0] dmaSel   [icg_pkg::NUM_DEV];
  logic [3:0] next_activate;
  logic [3:0] next_irqSel [icg_pkg::NUM_DEV];
  logic [2:0] next_dmaSel [icg_pkg::NUM_DEV];
  logic [7:0] modeReg;
  logic [7:0] optionReg;
  logic [7:0] typesReg;
  logic [7:0] drive0Reg;
  logic [7:0] drive1Reg;
  logic [7:0] next_modeReg;
  logic [7:0] next_optionReg;
  logic [7:0] next_typesReg;
  logic [7:0] next_drive0Reg;
  logic [7:0] next_drive1Reg;
  logic [7:0] next_cfgRdata;
  logic       devHit;
  logic [1:0] devIdx;
  logic       anyReset;

  function automatic logic [2:0] slot_of(input logic [7:0] ldn, output logic hit);
    hit = 1'b1;
    unique case (ldn)
      icg_pkg::LDN_FLOPPY:   slot_of = 3'h0;
      icg_pkg::LDN_PARALLEL: slot_of = 3'h1;
      icg_pkg::LDN_SERIAL1:  slot_of = 3'h2;
      icg_pkg::LDN_SERIAL2:  slot_of = 3'h3;
      default: begin
        hit = 1'b0;
        slot_of = 3'h0;
      end
    endcase
  endfunction

  function automatic logic [3:0] irq_reset_of(input int slot);
    irq_reset_of = (slot == 0) ? icg_pkg::RST_IRQ_FLOPPY[3:0] : icg_pkg::RST_IRQ_OTHER[3:0];
  endfunction

  function automatic logic [2:0] dma_reset_of(input int slot);
    dma_reset_of = (slot == 0) ? icg_pkg::RST_DMA_FLOPPY[2:0] : icg_pkg::RST_DMA_OTHER[2:0];
  endfunction

  always_comb begin
    logic [2:0] s;
    logic       h;
    s = slot_of(ldnSel, h);
    devHit = h;
    devIdx = s[1:0];
  end

  // Power-on (srst) restores everything and bus reset everything except cfgRdata; soft reset restores only the
  // standard activate/select registers.
  assign anyReset = srst || !bus_reset_n;

  always_comb begin
    next_activate = activate;
    next_irqSel   = irqSel;
    next_dmaSel   = dmaSel;
    if (softReset) begin
      next_activate = '0;
      for (int i = 0; i < icg_pkg::NUM_DEV; i++) begin
        next_irqSel[i] = irq_reset_of(i);
        next_dmaSel[i] = dma_reset_of(i);
      end
    end else if (cfgWrite && devHit) begin
      unique case (cfgIndex)
        icg_pkg::IDX_ACTIVATE:   next_activate[devIdx] = cfgWdata[0];
        icg_pkg::IDX_IRQ_SELECT: next_irqSel[devIdx]   = cfgWdata[3:0];
        icg_pkg::IDX_DMA_SELECT: next_dmaSel[devIdx]   = cfgWdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      activate <= '0;
      for (int i = 0; i < icg_pkg::NUM_DEV; i++) begin
        irqSel[i] <= irq_reset_of(i);
        dmaSel[i] <= dma_reset_of(i);
      end
    end else begin
      activate <= next_activate;
      irqSel   <= next_irqSel;
      dmaSel   <= next_dmaSel;
    end
  end

  // ----------------------------------------------------------------
  // Floppy vendor registers
  // ----------------------------------------------------------------
  always_comb begin
    next_modeReg   = modeReg;
    next_optionReg = optionReg;
    next_typesReg  = typesReg;
    next_drive0Reg = drive0Reg;
    next_drive1Reg = drive1Reg;
    if (cfgWrite && ldnSel == icg_pkg::LDN_FLOPPY) begin
      unique case (cfgIndex)
        icg_pkg::IDX_MODE:        next_modeReg   = cfgWdata;
        icg_pkg::IDX_OPTION:      next_optionReg = cfgWdata;
        icg_pkg::IDX_DRIVE_TYPES: next_typesReg  = cfgWdata;
        icg_pkg::IDX_DRIVE0:      next_drive0Reg = cfgWdata & icg_pkg::DRIVE_WR_MASK;
        icg_pkg::IDX_DRIVE1:      next_drive1Reg = cfgWdata & icg_pkg::DRIVE_WR_MASK;
        default: ;
      endcase
    end
  end

  // Soft reset is deliberately absent here.
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      modeReg   <= icg_pkg::RST_MODE;
      optionReg <= icg_pkg::RST_OPTION;
      typesReg  <= icg_pkg::RST_DRIVE_TYPES;
      drive0Reg <= icg_pkg::RST_DRIVE;
      drive1Reg <= icg_pkg::RST_DRIVE;
    end else begin
      modeReg   <= next_modeReg;
      optionReg <= next_optionReg;
      typesReg  <= next_typesReg;
      drive0Reg <= next_drive0Reg;
      drive1Reg <= next_drive1Reg;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    next_cfgRdata = '0;
    if (cfgRead && devHit) begin
      unique case (cfgIndex)
        icg_pkg::IDX_ACTIVATE:   next_cfgRdata = {7'h00, activate[devIdx]};
        icg_pkg::IDX_IRQ_SELECT: next_cfgRdata = {4'h0, irqSel[devIdx]};
        icg_pkg::IDX_DMA_SELECT: next_cfgRdata = {5'h00, dmaSel[devIdx]};
        default: ;
      endcase
    end
    if (cfgRead && ldnSel == icg_pkg::LDN_FLOPPY) begin
      unique case (cfgIndex)
        icg_pkg::IDX_MODE:        next_cfgRdata = modeReg;
        icg_pkg::IDX_OPTION:      next_cfgRdata = optionReg;
        icg_pkg::IDX_DRIVE_TYPES: next_cfgRdata = typesReg;
        icg_pkg::IDX_RSVD_ZERO:   next_cfgRdata = '0;
        icg_pkg::IDX_DRIVE0:      next_cfgRdata = drive0Reg;
        icg_pkg::IDX_DRIVE1:      next_cfgRdata = drive1Reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfgRdata <= '0;
    end else begin
      cfgRdata <= next_cfgRdata;
    end
  end

  // ----------------------------------------------------------------
  // Device request gating
  // ----------------------------------------------------------------
  logic [3:0] devIrq;
  logic [3:0] devDma;
  logic       parIrqEn;
  logic [NUM_IRQ-1:0] lineIrq [icg_pkg::NUM_DEV];
  logic [NUM_DMA-1:0] lineDma [icg_pkg::NUM_DEV];
  logic [3:0]         dmaOk;
  logic               floppyEn;
  logic               ecpActive;
  icg_pkg::icg_ecr_e  ecrMode;

  always_comb begin
    ecrMode   = icg_pkg::icg_ecr_e'(parEcr[icg_pkg::ECR_MODE_LSB +: 3]);
    ecpActive = !parEppMode;
    floppyEn  = floppyDor[icg_pkg::DOR_DMA_GATE] && !floppyPowerDown;
    unique case (ecrMode)
      icg_pkg::ECR_FIFO, icg_pkg::ECR_ECP, icg_pkg::ECR_TEST: parIrqEn = 1'b1;
      default: parIrqEn = parControl[icg_pkg::PCTL_IRQ_EN];
    endcase
    // Outside ECP operation the mode field is stale, so only the control bit gates.
    if (!ecpActive) begin
      parIrqEn = parControl[icg_pkg::PCTL_IRQ_EN];
    end
    if (ecpActive && parEcr[icg_pkg::ECR_SVC_MASK]) begin
      parIrqEn = 1'b0;
    end
    // Each term except devDma[2], which is tied low, folds the activate bit and address validity with local enables.
    devIrq[0] = activate[0] && devAddrValid[0] && floppyEn && floppyIrq;
    devDma[0] = activate[0] && devAddrValid[0] && floppyEn && floppyDrq;
    devIrq[1] = activate[1] && devAddrValid[1] && parIrqEn && parIrq;
    devDma[1] = activate[1] && devAddrValid[1] && parEcr[icg_pkg::ECR_DMA_EN] && parDrq;
    devIrq[2] = activate[2] && devAddrValid[2] && (|uart1IrqEnable[3:0])
                && uart1ModemControl[icg_pkg::MODEM_AUX2] && uart1Irq;
    devDma[2] = 1'b0;
    devIrq[3] = activate[3] && devAddrValid[3] && (|uart2IrqEnable[3:0])
                && uart2ModemControl[icg_pkg::MODEM_AUX2] && uart2Irq;
    devDma[3] = activate[3] && devAddrValid[3] && uart2DmaEnable && uart2Drq;
  end

  for (genvar g = 0; g < icg_pkg::NUM_DEV; g++) begin : gateGen
    icg_line_gate #(.NUM_IRQ(NUM_IRQ), .NUM_DMA(NUM_DMA)) u_gate (
      .irqSel   (irqSel[g]),
      .dmaSel   (dmaSel[g]),
      .irqReq   (devIrq[g]),
      .dmaReq   (devDma[g]),
      .irqLines (lineIrq[g]),
      .dmaLines (lineDma[g]),
      .dmaValid (dmaOk[g])
    );
  end

  // Unselected lines have no contributor and so stay low.
  always_comb begin
    logic [NUM_IRQ-1:0] accI;
    logic [NUM_DMA-1:0] accD;
    accI = '0;
    accD = '0;
    for (int i = 0; i < icg_pkg::NUM_DEV; i++) begin
      accI = accI | lineIrq[i];
      accD = accD | lineDma[i];
    end
    irqOut    = accI;
    dmaReqOut = accD;
  end

  // ----------------------------------------------------------------
  // Floppy pin control
  // ----------------------------------------------------------------
  always_comb begin
    if (modeReg[icg_pkg::MODE_SWAP]) begin
      drive_select_n = {driveSelectRaw_n[0], driveSelectRaw_n[1]};
      motor_on_n     = {motorOnRaw_n[0], motorOnRaw_n[1]};
    end else begin
      drive_select_n = driveSelectRaw_n;
      motor_on_n     = motorOnRaw_n;
    end
    // Open drain drives only low; push-pull drives always; the tristate bit overrides both.
    floppyPinOe = ~{motor_on_n, drive_select_n};
    if (modeReg[icg_pkg::MODE_PUSHPULL]) begin
      floppyPinOe = 4'hF;
    end
    if (modeReg[icg_pkg::MODE_TRISTATE]) begin
      floppyPinOe = 4'h0;
    end
    floppyPushPull   = modeReg[icg_pkg::MODE_PUSHPULL];
    floppyEnhanced   = modeReg[icg_pkg::MODE_ENHANCED];
    floppyNonBurst   = modeReg[icg_pkg::MODE_NONBURST];
    floppyIfMode     = modeReg[icg_pkg::MODE_IF_LSB +: 2];
    floppyOption     = optionReg;
    floppyDriveTypes = typesReg;
    driveTypeSel0    = drive0Reg[icg_pkg::DRV_TYPE_LSB +: 2];
    rateTableSel0    = drive0Reg[icg_pkg::DRV_RATE_LSB +: 2];
    precompDisable0  = drive0Reg[icg_pkg::DRV_PRECOMP];
    driveTypeSel1    = drive1Reg[icg_pkg::DRV_TYPE_LSB +: 2];
    rateTableSel1    = drive1Reg[icg_pkg::DRV_RATE_LSB +: 2];
    precompDisable1  = drive1Reg[icg_pkg::DRV_PRECOMP];
  end

endmodule

// ### icg_config_regs_sva.sv
// Port-level assertions for the configuration register block.
`timescale 1ns/1ns
module icg_config_regs_sva #(
  parameter int NUM_DMA = 4
) (
  input wire logic               ref_clk,
  input wire logic               srst,
  input wire logic               bus_reset_n,
  input wire logic               softReset,
  input wire logic [7:0]         ldnSel,
  input wire logic [7:0]         cfgIndex,
  input wire logic [7:0]         cfgWdata,
  input wire logic               cfgWrite,
  input wire logic               cfgRead,
  input wire logic [7:0]         cfgRdata,
  input wire logic [NUM_DMA-1:0] dmaReqOut,
  input wire logic [1:0]         driveSelectRaw_n,
  input wire logic [1:0]         drive_select_n,
  input wire logic [3:0]         floppyPinOe,
  input wire logic               floppyPushPull,
  input wire logic               floppyEnhanced,
  input wire logic               floppyNonBurst,
  input wire logic [1:0]         floppyIfMode,
  input wire logic [7:0]         floppyDriveTypes
);
  logic       hardRst;
  logic [7:0] mode;
  logic [7:0] next_mode;
  assign hardRst = srst || !bus_reset_n;
  // Shadow of the floppy mode register, rebuilt from the host writes.
  always_comb begin
    next_mode = mode;
    if (hardRst) begin
      next_mode = 8'h0E;
    end else if (cfgWrite && ldnSel == 8'h00 && cfgIndex == 8'hF0) begin
      next_mode = cfgWdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    mode <= next_mode;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (hardRst);
  sequence s_rd(logic [7:0] idx);
    cfgRead && !cfgWrite && ldnSel == 8'h00 && cfgIndex == idx;
  endsequence
  property p_swap;
    drive_select_n == (mode[4] ? {driveSelectRaw_n[0], driveSelectRaw_n[1]} : driveSelectRaw_n);
  endproperty
  a_swap: assert property (p_swap) else $error("drive swap wrong");
  property p_outputs;
    floppyPushPull == mode[6] && (!mode[7] || floppyPinOe == 4'h0);
  endproperty
  a_outputs: assert property (p_outputs) else $error("output type wrong");
  property p_mode;
    floppyEnhanced == mode[0] && floppyNonBurst == mode[1] && floppyIfMode == mode[3:2];
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_rsvd_zero;
    s_rd(8'hF3) |=> cfgRdata == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read wrong");
  property p_drive_rsvd;
    s_rd(8'hF4) |=> (cfgRdata & 8'hA4) == 8'h00;
  endproperty
  a_drive_rsvd: assert property (p_drive_rsvd) else $error("drive bits wrong");
  property p_types;
    s_rd(8'hF2) |=> cfgRdata == $past(floppyDriveTypes);
  endproperty
  a_types: assert property (p_types) else $error("type read wrong");
  property p_dma0;
    dmaReqOut[0] == 1'b0;
  endproperty
  a_dma0: assert property (p_dma0) else $error("channel 0 active");
  property p_soft;
    softReset && !cfgWrite |=> $stable(floppyDriveTypes) && $stable(floppyIfMode);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset hit vendor regs");
endmodule
bind icg_config_regs icg_config_regs_sva #(.NUM_DMA(NUM_DMA)) i_sva (
  .ref_clk, .srst, .bus_reset_n, .softReset, .ldnSel, .cfgIndex, .cfgWdata, .cfgWrite,
  .cfgRead, .cfgRdata, .dmaReqOut, .driveSelectRaw_n, .drive_select_n, .floppyPinOe,
  .floppyPushPull, .floppyEnhanced, .floppyNonBurst, .floppyIfMode, .floppyDriveTypes
);

// ### icg_host_model.sv
// Host model that issues configuration index/data cycles.
`timescale 1ns/1ns
module icg_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] ldnSel,
  output logic      [7:0] cfgIndex,
  output logic      [7:0] cfgWdata,
  output logic            cfgWrite,
  output logic            cfgRead,
  input  wire logic [7:0] cfgRdata
);
  initial begin
    {ldnSel, cfgIndex, cfgWdata, cfgWrite, cfgRead} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] l, input logic [7:0] i,
                      input logic [7:0] d, output logic [7:0] g);
    @(negedge ref_clk);
    ldnSel = l;
    cfgIndex = i;
    cfgWdata = d;
    cfgWrite = w;
    cfgRead = !w;
    @(negedge ref_clk);
    g = cfgRdata;
    {cfgWrite, cfgRead} = 2'b00;
    cfgIndex = ~i;
    cfgWdata = ~d;
  endtask
endmodule

// ### icg_config_regs_tb.sv
// Self-checking testbench for the configuration register block.
`timescale 1ns/1ns
module icg_config_regs_tb;
  logic        ref_clk, srst, bus_reset_n, softReset, floppyPowerDown, floppyIrq, floppyDrq;
  logic        parEppMode, parIrq, parDrq, uart1Irq, uart2Irq, uart2DmaEnable, uart2Drq;
  logic        floppyPushPull, floppyEnhanced, floppyNonBurst, precompDisable1, cfgWrite, cfgRead;
  logic [1:0]  driveSelectRaw_n, motorOnRaw_n, drive_select_n, motor_on_n, floppyIfMode;
  logic [1:0]  rateTableSel0, driveTypeSel0;
  logic [3:0]  devAddrValid, floppyPinOe, dmaReqOut;
  logic [7:0]  ldnSel, cfgIndex, cfgWdata, cfgRdata, floppyDor, parControl, parEcr;
  logic [7:0]  uart1IrqEnable, uart1ModemControl, uart2IrqEnable, uart2ModemControl;
  logic [7:0]  floppyDriveTypes, floppyOption;
  logic [15:0] irqOut;
  int          n_fail, comparisons, cycles;
  icg_config_regs i_dut (
    .ref_clk, .srst, .bus_reset_n, .softReset, .ldnSel, .cfgIndex, .cfgWdata, .cfgWrite,
    .cfgRead, .cfgRdata, .devAddrValid, .floppyDor, .floppyPowerDown, .floppyIrq, .floppyDrq,
    .parControl, .parEcr, .parEppMode, .parIrq, .parDrq, .uart1IrqEnable, .uart1ModemControl,
    .uart1Irq, .uart2IrqEnable, .uart2ModemControl, .uart2Irq, .uart2DmaEnable, .uart2Drq,
    .driveSelectRaw_n, .motorOnRaw_n, .irqOut, .dmaReqOut, .drive_select_n, .motor_on_n,
    .floppyPinOe, .floppyPushPull, .floppyEnhanced, .floppyNonBurst, .floppyIfMode,
    .floppyOption, .floppyDriveTypes, .driveTypeSel0, .rateTableSel0, .precompDisable0(),
    .driveTypeSel1(), .rateTableSel1(), .precompDisable1
  );
  icg_host_model i_host (
    .ref_clk, .ldnSel, .cfgIndex, .cfgWdata, .cfgWrite, .cfgRead, .cfgRdata
  );
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("CHECK FAILED run time expected finish seen hang");
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
    logic [7:0] g;
    i_host.xfer(1'b1, l, i, d, g);
  endtask
  task automatic rdc(input logic [7:0] l, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] g;
    i_host.xfer(1'b0, l, i, 8'h00, g);
    chk($sformatf("reg %h.%h", l, i), {8'h00, e}, {8'h00, g});
  endtask
  task automatic gate(input logic [15:0] ei, input logic [3:0] ed);
    #1;
    chk("irqOut", ei, irqOut);
    chk("dmaReqOut", {12'h000, ed}, {12'h000, dmaReqOut});
    @(negedge ref_clk);
  endtask
  initial begin
    {srst, bus_reset_n, devAddrValid, driveSelectRaw_n, motorOnRaw_n} = 10'h3F9;
    {softReset, floppyPowerDown, floppyIrq, floppyDrq, parEppMode, parIrq, parDrq} = '0;
    {uart1Irq, uart2Irq, uart2DmaEnable, uart2Drq, parControl, parEcr} = '0;
    {uart1IrqEnable, uart1ModemControl, uart2IrqEnable, uart2ModemControl} = '0;
    floppyDor = 8'h08;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    rdc(8'h00, 8'h70, 8'h06);
    rdc(8'h04, 8'h70, 8'h00);
    rdc(8'h00, 8'h74, 8'h02);
    rdc(8'h03, 8'h74, 8'h04);
    rdc(8'h05, 8'h74, 8'h04);
    rdc(8'h00, 8'hF0, 8'h0E);
    rdc(8'h00, 8'hF2, 8'hFF);
    rdc(8'h00, 8'hF5, 8'h00);
    $display("test reset_values done");
    wr(8'h00, 8'hF4, 8'hFF);
    rdc(8'h00, 8'hF4, 8'h5B);
    chk("rateTableSel0", 16'h0003, {14'h0, rateTableSel0});
    chk("driveTypeSel0", 16'h0003, {14'h0, driveTypeSel0});
    wr(8'h00, 8'hF5, 8'h44);
    chk("precompDisable1", 16'h0001, {15'h0, precompDisable1});
    wr(8'h00, 8'hF3, 8'hFF);
    rdc(8'h00, 8'hF3, 8'h00);
    wr(8'h00, 8'hF2, 8'h5A);
    chk("floppyDriveTypes", 16'h005A, {8'h00, floppyDriveTypes});
    wr(8'h00, 8'hF1, 8'hA5);
    chk("floppyOption", 16'h00A5, {8'h00, floppyOption});
    $display("test drive_regs done");
    wr(8'h00, 8'hF0, 8'h1E);
    chk("drive_select_n", 16'h0001, {14'h0, drive_select_n});
    chk("motor_on_n", 16'h0002, {14'h0, motor_on_n});
    wr(8'h00, 8'hF0, 8'hC5);
    chk("drive_select_n", 16'h0002, {14'h0, drive_select_n});
    chk("floppyIfMode", 16'h0001, {14'h0, floppyIfMode});
    chk("floppyPushPull", 16'h0001, {15'h0, floppyPushPull});
    chk("modeBits", 16'h0002, {14'h0, floppyEnhanced, floppyNonBurst});
    chk("floppyPinOe", 16'h0000, {12'h0, floppyPinOe});
    $display("test mode done");
    wr(8'h00, 8'h70, 8'h03);
    softReset = 1'b1;
    @(negedge ref_clk);
    softReset = 1'b0;
    rdc(8'h00, 8'hF2, 8'h5A);
    rdc(8'h00, 8'hF1, 8'hA5);
    rdc(8'h00, 8'h70, 8'h06);
    bus_reset_n = 1'b0;
    @(negedge ref_clk);
    bus_reset_n = 1'b1;
    rdc(8'h00, 8'hF2, 8'hFF);
    rdc(8'h00, 8'hF1, 8'h00);
    chk("floppyPinOe", 16'h0009, {12'h0, floppyPinOe});
    $display("test resets done");
    {floppyIrq, floppyDrq} = 2'b11;
    gate(16'h0000, 4'h0);
    wr(8'h00, 8'h30, 8'h01);
    gate(16'h0040, 4'h4);
    floppyDor = 8'hF7;
    gate(16'h0000, 4'h0);
    {floppyDor, floppyPowerDown} = 9'h011;
    gate(16'h0000, 4'h0);
    {floppyPowerDown, devAddrValid} = 5'h0E;
    gate(16'h0000, 4'h0);
    devAddrValid = 4'hF;
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, 8'h74, 8'(s));
      gate(16'h0040, (s > 0 && s < 4) ? 4'(1 << s) : 4'h0);
    end
    wr(8'h00, 8'h70, 8'h00);
    gate(16'h0000, 4'h0);
    {floppyIrq, floppyDrq} = 2'b00;
    $display("test floppy_gating done");
    wr(8'h03, 8'h30, 8'h01);
    wr(8'h03, 8'h70, 8'h07);
    wr(8'h03, 8'h74, 8'h03);
    {parEppMode, parIrq, parDrq, parEcr} = 11'h748;
    gate(16'h0000, 4'h8);
    parControl = 8'h10;
    gate(16'h0080, 4'h8);
    {parEppMode, parControl} = 9'h000;
    for (int m = 0; m < 8; m++) begin
      parEcr = {3'(m), 5'h00};
      gate((m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0000, 4'h0);
    end
    {parControl, parEcr} = 16'h100C;
    gate(16'h0000, 4'h8);
    {parIrq, parDrq} = 2'b00;
    $display("test parallel_gating done");
    wr(8'h04, 8'h30, 8'h01);
    wr(8'h04, 8'h70, 8'h04);
    wr(8'h05, 8'h30, 8'h01);
    wr(8'h05, 8'h70, 8'h03);
    wr(8'h05, 8'h74, 8'h01);
    {uart1Irq, uart2Irq, uart2Drq, uart1IrqEnable, uart1ModemControl} = 19'h71008;
    gate(16'h0000, 4'h0);
    uart1IrqEnable = 8'h08;
    gate(16'h0010, 4'h0);
    {uart1ModemControl, uart2IrqEnable, uart2ModemControl, uart2DmaEnable} = 25'h1EE0211;
    gate(16'h0008, 4'h2);
    $display("test serial_gating done");
    tally_and_finish();
  end
endmodule
